// ===== bench/psc_ctrl_monitor.sv
// pin-level assertion checker for the pseudo-static memory controller
`timescale 1ns/1ns
module psc_ctrl_monitor #(
    parameter int POWER_UP_CYC = psc_pkg::CYC_POWER_UP,
    parameter int SLEEP_LOW_CYC = psc_pkg::CYC_SLEEP_LOW,
    parameter int RECOVERY_CYC = psc_pkg::CYC_RECOVERY
) (
    input wire logic core_clk, // clock
    input wire logic reset_n, // reset
    input wire logic req_valid, // request
    input wire logic req_ready, // taken
    input wire psc_pkg::psc_req_t req, // fields
    input wire logic rsp_valid, // done
    input wire logic [psc_pkg::DATA_W-1:0] rsp_rdata, // read data
    input wire logic init_done, // ready
    input wire logic chip_sel_n, // strobe
    input wire logic out_en_n, // strobe
    input wire logic write_en_n, // strobe
    input wire logic lower_byte_sel_n, // strobe
    input wire logic upper_byte_sel_n, // strobe
    input wire logic sleep_pin_n, // sleep
    input wire logic [psc_pkg::ADDR_W-1:0] mem_addr, // address
    input wire logic [psc_pkg::DATA_W-1:0] dq_out, // data out
    input wire logic [psc_pkg::DATA_W-1:0] dq_oe_n, // drive enable
    input wire logic [psc_pkg::DATA_W-1:0] dq_in // data in
);
    int cs_cnt;
    int slp_cnt;
    int boot_cnt;
    int rec_cnt;
    logic booted;
    logic cfg_seen;
    logic deep_power_down;
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cs_cnt <= 0;
            slp_cnt <= 0;
            boot_cnt <= 0;
            rec_cnt <= 0;
            booted <= 1'b0;
            cfg_seen <= 1'b0;
            deep_power_down <= 1'b0;
        end
        else
        begin
            cs_cnt <= chip_sel_n ? 0 : cs_cnt + 1;
            slp_cnt <= sleep_pin_n ? 0 : slp_cnt + 1;
            rec_cnt <= !sleep_pin_n ? 0 : (init_done ? rec_cnt : rec_cnt + 1);
            boot_cnt <= (booted || init_done) ? boot_cnt : boot_cnt + 1;
            booted <= booted | init_done;
            cfg_seen <= sleep_pin_n ? 1'b0 : (cfg_seen | ~write_en_n);
            if (req_valid && req_ready && req.cmd == psc_pkg::PSC_CMD_CONFIG)
                deep_power_down <= !req.addr[psc_pkg::CFG_SLEEP_BIT];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_cfg_strobe;
        $fell(write_en_n) && !sleep_pin_n;
    endsequence
    sequence s_wake;
        $rose(sleep_pin_n) && !cfg_seen;
    endsequence
    a_cs_max_len: assert property (cs_cnt < psc_pkg::CYC_MAX_SELECT)
        else $error("chip select held too long");
    a_write_needs_cs: assert property (!write_en_n |-> !chip_sel_n)
        else $error("write strobe without chip select");
    a_write_bytes_on: assert property (!write_en_n && sleep_pin_n |->
        !(lower_byte_sel_n && upper_byte_sel_n))
        else $error("write without byte select");
    a_write_data_drive: assert property (!write_en_n && !lower_byte_sel_n |->
        dq_oe_n[7:0] == 8'h00)
        else $error("write data not driven");
    a_cfg_we_delay: assert property (s_cfg_strobe |-> slp_cnt >= 1 && slp_cnt <= 5)
        else $error("config strobe outside window");
    a_sleep_deselect: assert property ($fell(sleep_pin_n) |->
        chip_sel_n && $past(chip_sel_n))
        else $error("sleep pin fell while selected");
    a_sleep_low_len: assert property (s_wake |-> slp_cnt >= SLEEP_LOW_CYC)
        else $error("sleep low too short");
    a_dpd_recovery: assert property ($rose(init_done) && booted && deep_power_down |->
        rec_cnt >= RECOVERY_CYC - 1)
        else $error("power-down recovery too short");
    a_boot_wait: assert property ($rose(init_done) && !booted |->
        boot_cnt >= POWER_UP_CYC - 1)
        else $error("power-up wait too short");
    a_no_early_access: assert property (!init_done |-> chip_sel_n throughout ##1 1)
        else $error("access before ready");
endmodule : psc_ctrl_monitor
bind psc_ctrl psc_ctrl_monitor #(.POWER_UP_CYC(POWER_UP_CYC), .SLEEP_LOW_CYC(SLEEP_LOW_CYC),
    .RECOVERY_CYC(RECOVERY_CYC)) i_mon (.core_clk(core_clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .init_done(init_done), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_en_n(write_en_n), .lower_byte_sel_n(lower_byte_sel_n),
    .upper_byte_sel_n(upper_byte_sel_n), .sleep_pin_n(sleep_pin_n), .mem_addr(mem_addr),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));

// ===== bench/psc_mem_model.sv
// behavioural pseudo-static memory answering the controller pins
`timescale 1ns/1ns
module psc_mem_model (
    input wire logic slow, // answer at the longest access time
    input wire logic chip_sel_n, // chip select
    input wire logic out_en_n, // output enable
    input wire logic write_en_n, // write enable
    input wire logic lower_byte_sel_n, // low byte select
    input wire logic upper_byte_sel_n, // high byte select
    input wire logic sleep_pin_n, // sleep pin
    input wire logic [psc_pkg::ADDR_W-1:0] mem_addr, // address
    input wire logic [psc_pkg::DATA_W-1:0] dq_out, // data from controller
    input wire logic [psc_pkg::DATA_W-1:0] dq_oe_n, // controller drive enable
    output logic [psc_pkg::DATA_W-1:0] dq_in // data seen by controller
);
    logic [15:0] mem [int];
    logic [20:0] config_reg = psc_pkg::CFG_RESET;
    logic [15:0] word, last, drv, fast, late, wr;
    logic rd_on;
    always @* word = mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : 16'h0000;
    assign rd_on = !chip_sel_n && !out_en_n && write_en_n;
    always @* if (rd_on) last = word;
    // released lanes show the inverse of the last read value
    always @*
    begin
        drv = ~last;
        if (rd_on && !lower_byte_sel_n) drv[7:0] = word[7:0];
        if (rd_on && !upper_byte_sel_n) drv[15:8] = word[15:8];
    end
    assign #20 fast = drv;
    assign #70 late = drv;
    assign dq_in = slow ? late : fast;
    always @(negedge write_en_n)
    begin
        #40;
        wr = word;
        if (!lower_byte_sel_n && dq_oe_n[7:0] == 8'h00) wr[7:0] = dq_out[7:0];
        if (!upper_byte_sel_n && dq_oe_n[15:8] == 8'h00) wr[15:8] = dq_out[15:8];
        if (!chip_sel_n && !sleep_pin_n) config_reg = mem_addr;
        else if (!chip_sel_n) mem[int'(mem_addr)] = wr;
    end
    // deep power-down loses the array; the wait outlasts a config load
    always @(negedge sleep_pin_n)
    begin
        #600;
        if (!sleep_pin_n && !config_reg[psc_pkg::CFG_SLEEP_BIT]) mem.delete();
    end
endmodule : psc_mem_model

// ===== bench/test_psc_ctrl.sv
// self-checking testbench for the pseudo-static memory controller
`timescale 1ns/1ns
module test_psc_ctrl;
    localparam int PU = 20;
    localparam int SL = 10;
    localparam int RC = 20;
    logic core_clk, reset_n, req_valid, req_ready, rsp_valid, init_done, slow;
    psc_pkg::psc_req_t req;
    logic [15:0] rsp_rdata, dq_out, dq_oe_n, dq_in, rd;
    logic [20:0] mem_addr;
    logic cs_n, oe_n, we_n, lb_n, ub_n, sleep_pin_n;
    logic [15:0] shadow [8];
    int err_count, cmp_count, cyc, w_rdy, w_rsp;
    psc_ctrl #(.POWER_UP_CYC(PU), .SLEEP_LOW_CYC(SL), .RECOVERY_CYC(RC)) i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .init_done(init_done), .chip_sel_n(cs_n), .out_en_n(oe_n), .write_en_n(we_n),
        .lower_byte_sel_n(lb_n), .upper_byte_sel_n(ub_n), .sleep_pin_n(sleep_pin_n),
        .mem_addr(mem_addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
    psc_mem_model i_mem (.slow(slow), .chip_sel_n(cs_n), .out_en_n(oe_n),
        .write_en_n(we_n), .lower_byte_sel_n(lb_n), .upper_byte_sel_n(ub_n),
        .sleep_pin_n(sleep_pin_n), .mem_addr(mem_addr), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .dq_in(dq_in));
    always #50 core_clk = ~core_clk;
    function automatic logic [15:0] lanes(input logic [1:0] be);
        return {{8{be[1]}}, {8{be[0]}}};
    endfunction : lanes
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check
    // drive one request, hold it until taken, then wait for the answer when wait_rsp is set
    task automatic run_req(input psc_pkg::psc_cmd_t cmd, input logic [20:0] a,
        input logic [15:0] d, input logic [1:0] be, input logic wait_rsp);
        req_valid <= 1'b1;
        req <= '{cmd: cmd, addr: a, wdata: d, byte_en: be};
        w_rdy = 0;
        do begin @(negedge core_clk); w_rdy++; end while (req_ready !== 1'b1 && w_rdy < 4000);
        @(posedge core_clk);
        req_valid <= 1'b0;
        req <= '{cmd: cmd, addr: ~a, wdata: ~d, byte_en: ~be};
        w_rsp = 0;
        while (wait_rsp && rsp_valid !== 1'b1 && w_rsp < 4000)
        begin
            @(negedge core_clk);
            w_rsp++;
        end
        rd = rsp_rdata;
        if (wait_rsp) check("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
        @(posedge core_clk);
    endtask : run_req
    task automatic write_word(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
        run_req(psc_pkg::PSC_CMD_WRITE, {18'h0_0000, a}, d, be, 1'b1);
        shadow[a] = (shadow[a] & ~lanes(be)) | (d & lanes(be));
    endtask : write_word
    task automatic read_word(input logic [2:0] a, input logic [1:0] be);
        run_req(psc_pkg::PSC_CMD_READ, {18'h0_0000, a}, 16'h0000, be, 1'b1);
        check("read_data", shadow[a] & lanes(be), rd & lanes(be));
    endtask : read_word
    task automatic sleep_round(input logic deep_power_down);
        logic [20:0] cfg;
        cfg = psc_pkg::CFG_RESET;
        cfg[psc_pkg::CFG_SLEEP_BIT] = !deep_power_down;
        cfg[psc_pkg::CFG_PAGE_BIT] = 1'($urandom_range(1));
        run_req(psc_pkg::PSC_CMD_CONFIG, cfg, 16'h0000, 2'h3, 1'b1);
        run_req(psc_pkg::PSC_CMD_SLEEP, 21'h00_0000, 16'h0000, 2'h3, 1'b0);
        run_req(psc_pkg::PSC_CMD_READ, 21'h00_0000, 16'h0000, 2'h3, 1'b1);
        check("sleep_low_long", 16'h0001, {15'h0000, w_rdy >= SL - 2});
        check("recovery_wait", 16'h0001, {15'h0000, deep_power_down ? w_rsp >= RC : w_rsp < RC});
        check("ready_after_wake", 16'h0001, {15'h0000, init_done});
        if (deep_power_down)
            foreach (shadow[k]) shadow[k] = 16'h0000;
        read_word(3'h2, 2'h3);
    endtask : sleep_round
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end
    initial
    begin
        void'($urandom(42));
        core_clk = 1'b0;
        reset_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        slow = 1'b0;
        cyc = 0;
        foreach (shadow[k]) shadow[k] = 16'h0000;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        w_rdy = 0;
        while (init_done !== 1'b1 && w_rdy < 200) begin @(negedge core_clk); w_rdy++; end
        check("power_up_wait", 16'h0001, {15'h0000, w_rdy >= PU - 1});
        @(posedge core_clk);
        for (int i = 0; i < 24; i++)
            write_word(3'($urandom_range(7)), 16'($urandom), 2'($urandom_range(3, 1)));
        write_word(3'h7, 16'hFFFF, 2'h3);
        write_word(3'h7, 16'h0000, 2'h1);
        for (int i = 0; i < 16; i++)
        begin
            slow <= i[3];
            read_word(3'(i), 2'($urandom_range(3, 1)));
        end
        slow <= 1'b0;
        sleep_round(1'b0);
        sleep_round(1'b1);
        write_word(3'h2, 16'hA5C3, 2'h3);
        read_word(3'h2, 2'h2);
        print_verdict();
    end
endmodule : test_psc_ctrl

// ===== core/psc_ctrl.sv
// controller that drives the pseudo-static memory through its pins
`timescale 1ns/1ns
module psc_ctrl #(
    parameter int POWER_UP_CYC = psc_pkg::CYC_POWER_UP,
    parameter int SLEEP_LOW_CYC = psc_pkg::CYC_SLEEP_LOW,
    parameter int RECOVERY_CYC = psc_pkg::CYC_RECOVERY
) (
    input wire logic core_clk, // system clock, 10 MHz
    input wire logic reset_n, // async reset, active low
    input wire logic req_valid, // request present
    output logic req_ready, // request taken this cycle
    input wire psc_pkg::psc_req_t req, // request fields
    output logic rsp_valid, // read data or completion pulse
    output logic [psc_pkg::DATA_W-1:0] rsp_rdata, // read data
    output logic init_done, // memory ready for access
    output logic chip_sel_n, // memory chip select, low active
    output logic out_en_n, // memory output enable, low active
    output logic write_en_n, // memory write enable, low active
    output logic lower_byte_sel_n, // low byte select, low active
    output logic upper_byte_sel_n, // high byte select, low active
    output logic sleep_pin_n, // sleep pin, low active
    output logic [psc_pkg::ADDR_W-1:0] mem_addr, // memory address
    output logic [psc_pkg::DATA_W-1:0] dq_out, // data toward memory
    output logic [psc_pkg::DATA_W-1:0] dq_oe_n, // data drive enable, low drives
    input wire logic [psc_pkg::DATA_W-1:0] dq_in // data from memory pins
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [9:0] {
        ST_POWER_UP = 10'h001,
        ST_IDLE = 10'h002,
        ST_READ = 10'h004,
        ST_WRITE = 10'h008,
        ST_WE_HIGH = 10'h010,
        ST_DESEL = 10'h020,
        ST_CFG_SETUP = 10'h040,
        ST_CFG_WRITE = 10'h080,
        ST_SLEEP_LOW = 10'h100,
        ST_RECOVER = 10'h200
    } psc_state_t;

    localparam logic [psc_pkg::CNT_W-1:0] CNT_READ = psc_pkg::CNT_W'(psc_pkg::CYC_READ);
    localparam logic [psc_pkg::CNT_W-1:0] CNT_WPULSE =
        psc_pkg::CNT_W'(psc_pkg::CYC_WRITE_PULSE);
    localparam logic [psc_pkg::CNT_W-1:0] CNT_WHIGH = psc_pkg::CNT_W'(psc_pkg::CYC_WRITE_HIGH);
    localparam logic [psc_pkg::CNT_W-1:0] CNT_SELHIGH = psc_pkg::CNT_W'(psc_pkg::CYC_SEL_HIGH);
    localparam logic [psc_pkg::CNT_W-1:0] CNT_DSLEEP =
        psc_pkg::CNT_W'(psc_pkg::CYC_DESEL_SLEEP);
    localparam logic [psc_pkg::CNT_W-1:0] CNT_SLEEP_WE = psc_pkg::CNT_W'(psc_pkg::CYC_SLEEP_WE);
    localparam logic [psc_pkg::CNT_W-1:0] CNT_PU = psc_pkg::CNT_W'(POWER_UP_CYC);
    localparam logic [psc_pkg::CNT_W-1:0] CNT_SLOW = psc_pkg::CNT_W'(SLEEP_LOW_CYC);
    localparam logic [psc_pkg::CNT_W-1:0] CNT_RECOV = psc_pkg::CNT_W'(RECOVERY_CYC);

    psc_state_t state;
    psc_state_t next_state;
    psc_pkg::psc_pins_t pins;
    psc_pkg::psc_pins_t next_pins;
    logic [psc_pkg::DATA_W-1:0] rdata;
    logic [psc_pkg::DATA_W-1:0] next_rdata;
    logic rsp;
    logic next_rsp;
    logic ready_flag;
    logic next_ready_flag;
    logic sleep_is_dpd;
    logic next_sleep_is_dpd;
    logic t_load;
    logic [psc_pkg::CNT_W-1:0] t_value;
    logic t_done;
    logic [psc_pkg::DATA_W-1:0] dq_sync;
    logic init_seen;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    psc_timer #(.WIDTH(psc_pkg::CNT_W)) u_timer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .load(t_load),
        .value(t_value),
        .done(t_done)
    );

    psc_sync #(.WIDTH(psc_pkg::DATA_W)) u_dq_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .din(dq_in),
        .dout(dq_sync)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_pins = pins;
        next_rdata = rdata;
        next_rsp = 1'b0;
        next_ready_flag = ready_flag;
        next_sleep_is_dpd = sleep_is_dpd;
        t_load = 1'b0;
        t_value = '0;
        req_ready = 1'b0;
        unique case (state)
            ST_POWER_UP:
            begin
                if (!init_seen)
                begin
                    t_load = 1'b1;
                    t_value = CNT_PU;
                end
                else if (t_done)
                begin
                    next_ready_flag = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    req_ready = 1'b1;
                    next_pins.addr = req.addr;
                    unique case (req.cmd)
                        psc_pkg::PSC_CMD_READ:
                        begin
                            next_pins.chip_sel_n = 1'b0;
                            next_pins.out_en_n = 1'b0;
                            next_pins.lower_byte_sel_n = ~req.byte_en[0];
                            next_pins.upper_byte_sel_n = ~req.byte_en[1];
                            t_load = 1'b1;
                            t_value = CNT_READ;
                            next_state = ST_READ;
                        end
                        psc_pkg::PSC_CMD_WRITE:
                        begin
                            // address, select, bytes and data all start with the strobe
                            next_pins.chip_sel_n = 1'b0;
                            next_pins.write_en_n = 1'b0;
                            next_pins.lower_byte_sel_n = ~req.byte_en[0];
                            next_pins.upper_byte_sel_n = ~req.byte_en[1];
                            next_pins.dq_out = req.wdata;
                            next_pins.dq_oe_n = '0;
                            t_load = 1'b1;
                            t_value = CNT_WPULSE;
                            next_state = ST_WRITE;
                        end
                        psc_pkg::PSC_CMD_CONFIG:
                        begin
                            next_pins.sleep_pin_n = 1'b0;
                            next_sleep_is_dpd = ~req.addr[psc_pkg::CFG_SLEEP_BIT];
                            t_load = 1'b1;
                            t_value = CNT_SLEEP_WE;
                            next_state = ST_CFG_SETUP;
                        end
                        default:
                        begin
                            // chip is already deselected in idle for the margin
                            t_load = 1'b1;
                            t_value = CNT_DSLEEP;
                            next_state = ST_DESEL;
                        end
                    endcase
                end
            end
            ST_READ:
            begin
                if (t_done)
                begin
                    next_rdata = dq_sync;
                    next_rsp = 1'b1;
                    next_pins.chip_sel_n = 1'b1;
                    next_pins.out_en_n = 1'b1;
                    next_pins.lower_byte_sel_n = 1'b1;
                    next_pins.upper_byte_sel_n = 1'b1;
                    t_load = 1'b1;
                    t_value = CNT_SELHIGH;
                    next_state = ST_WE_HIGH;
                end
            end
            ST_WRITE:
            begin
                if (t_done)
                begin
                    // data is held to the edge; released with the strobe
                    next_pins.write_en_n = 1'b1;
                    next_pins.chip_sel_n = 1'b1;
                    next_pins.lower_byte_sel_n = 1'b1;
                    next_pins.upper_byte_sel_n = 1'b1;
                    next_pins.dq_oe_n = '1;
                    next_rsp = 1'b1;
                    t_load = 1'b1;
                    t_value = CNT_WHIGH;
                    next_state = ST_WE_HIGH;
                end
            end
            ST_WE_HIGH:
            begin
                if (t_done)
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_CFG_SETUP:
            begin
                if (t_done)
                begin
                    // write strobe follows sleep low within the allowed window
                    next_pins.chip_sel_n = 1'b0;
                    next_pins.write_en_n = 1'b0;
                    t_load = 1'b1;
                    t_value = CNT_WPULSE;
                    next_state = ST_CFG_WRITE;
                end
            end
            ST_CFG_WRITE:
            begin
                if (t_done)
                begin
                    next_pins.write_en_n = 1'b1;
                    next_pins.chip_sel_n = 1'b1;
                    next_pins.sleep_pin_n = 1'b1;
                    next_rsp = 1'b1;
                    t_load = 1'b1;
                    t_value = CNT_WHIGH;
                    next_state = ST_WE_HIGH;
                end
            end
            ST_DESEL:
            begin
                if (t_done)
                begin
                    next_pins.sleep_pin_n = 1'b0;
                    next_ready_flag = 1'b0;
                    t_load = 1'b1;
                    t_value = CNT_SLOW;
                    next_state = ST_SLEEP_LOW;
                end
            end
            ST_SLEEP_LOW:
            begin
                if (t_done && !req_valid)
                begin
                    // a request ends the low phase only after the least width
                    next_state = ST_SLEEP_LOW;
                end
                else if (t_done)
                begin
                    req_ready = 1'b1;
                    next_pins.sleep_pin_n = 1'b1;
                    t_load = 1'b1;
                    t_value = sleep_is_dpd ? CNT_RECOV : 16'h0001;
                    next_state = ST_RECOVER;
                end
            end
            ST_RECOVER:
            begin
                if (t_done)
                begin
                    next_ready_flag = 1'b1;
                    next_rsp = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // starts the power-up count once after reset
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            init_seen <= 1'b0;
        end
        else
        begin
            init_seen <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_POWER_UP;
            pins <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1,
                lower_byte_sel_n: 1'b1, upper_byte_sel_n: 1'b1, sleep_pin_n: 1'b1,
                addr: '0, dq_out: '0, dq_oe_n: '1};
            rdata <= '0;
            rsp <= 1'b0;
            ready_flag <= 1'b0;
            sleep_is_dpd <= ~psc_pkg::CFG_RESET[psc_pkg::CFG_SLEEP_BIT];
        end
        else
        begin
            state <= next_state;
            pins <= next_pins;
            rdata <= next_rdata;
            rsp <= next_rsp;
            ready_flag <= next_ready_flag;
            sleep_is_dpd <= next_sleep_is_dpd;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rsp_valid = rsp;
    assign rsp_rdata = rdata;
    assign init_done = ready_flag;
    assign chip_sel_n = pins.chip_sel_n;
    assign out_en_n = pins.out_en_n;
    assign write_en_n = pins.write_en_n;
    assign lower_byte_sel_n = pins.lower_byte_sel_n;
    assign upper_byte_sel_n = pins.upper_byte_sel_n;
    assign sleep_pin_n = pins.sleep_pin_n;
    assign mem_addr = pins.addr;
    assign dq_out = pins.dq_out;
    assign dq_oe_n = pins.dq_oe_n;
endmodule : psc_ctrl

// ===== core/psc_pkg.sv
// package of constants and types for the pseudo-static memory controller
package psc_pkg;
    // clock figures
    localparam int CLK_PERIOD_NS = 100;
    // documented times
    localparam int T_READ_ACCESS_NS = 70;
    localparam int T_HIGHZ_NS = 8;
    localparam int T_WRITE_CYCLE_NS = 70;
    localparam int T_WRITE_PULSE_NS = 46;
    localparam int T_WRITE_HIGH_NS = 10;
    localparam int T_DATA_SETUP_NS = 23;
    localparam int T_SEL_HIGH_NS = 5;
    localparam int T_DESEL_SLEEP_NS = 5;
    localparam int T_SLEEP_WE_MIN_NS = 10;
    localparam int T_SLEEP_WE_MAX_NS = 500;
    localparam int T_MAX_SELECT_US = 8;
    localparam int T_SLEEP_LOW_US = 10;
    localparam int T_RECOVERY_US = 150;
    localparam int T_POWER_UP_US = 150;
    // least times round up, longest round down, none below one cycle
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min
    function automatic int cyc_max(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_max
    // read waits for access plus one sampling cycle of margin
    localparam int CYC_READ = cyc_min(T_READ_ACCESS_NS) + 1;
    localparam int CYC_TURN = cyc_min(T_HIGHZ_NS);
    localparam int CYC_WRITE_PULSE = cyc_min(T_WRITE_CYCLE_NS);
    localparam int CYC_WRITE_HIGH = cyc_min(T_WRITE_HIGH_NS);
    localparam int CYC_SEL_HIGH = cyc_min(T_SEL_HIGH_NS);
    localparam int CYC_DESEL_SLEEP = cyc_min(T_DESEL_SLEEP_NS);
    localparam int CYC_SLEEP_WE = cyc_min(T_SLEEP_WE_MIN_NS);
    localparam int CYC_SLEEP_WE_MAX = cyc_max(T_SLEEP_WE_MAX_NS);
    localparam int CYC_MAX_SELECT = cyc_max(T_MAX_SELECT_US * 1000);
    localparam int CYC_SLEEP_LOW = cyc_min(T_SLEEP_LOW_US * 1000);
    localparam int CYC_RECOVERY = cyc_min(T_RECOVERY_US * 1000);
    localparam int CYC_POWER_UP = cyc_min(T_POWER_UP_US * 1000);
    // configuration word fields
    localparam int CFG_PAGE_BIT = 7;
    localparam int CFG_SLEEP_BIT = 4;
    localparam logic [20:0] CFG_RESET = 21'h00_0070;
    // widths
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    // user commands
    typedef enum logic [2:0] {
        PSC_CMD_READ = 3'h0,
        PSC_CMD_WRITE = 3'h1,
        PSC_CMD_CONFIG = 3'h2,
        PSC_CMD_SLEEP = 3'h3
    } psc_cmd_t;
    typedef struct packed {
        psc_cmd_t cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0] byte_en;
    } psc_req_t;
    // pins driven toward the memory
    typedef struct packed {
        logic chip_sel_n;
        logic out_en_n;
        logic write_en_n;
        logic lower_byte_sel_n;
        logic upper_byte_sel_n;
        logic sleep_pin_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic [DATA_W-1:0] dq_oe_n;
    } psc_pins_t;
endpackage : psc_pkg

// ===== core/psc_sync.sv
// two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ns
module psc_sync #(
    parameter int WIDTH = 16
) (
    input wire logic core_clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic [WIDTH-1:0] din, // asynchronous input
    output logic [WIDTH-1:0] dout // synchronised output
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_stage2;
    always_comb
    begin
        next_stage1 = din;
        next_stage2 = stage1;
    end
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1 <= '0;
            stage2 <= '0;
        end
        else
        begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end
    assign dout = stage2;
endmodule : psc_sync

// ===== core/psc_timer.sv
// loadable down counter that flags when it reaches zero
`timescale 1ns/1ns
module psc_timer #(
    parameter int WIDTH = 16
) (
    input wire logic core_clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic load, // load a new count
    input wire logic [WIDTH-1:0] value, // cycles to count
    output logic done // count is zero
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    always_comb
    begin
        next_count = count;
        if (load)
        begin
            next_count = value;
        end
        else if (count != '0)
        begin
            next_count = count - 1'b1;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count;
        end
    end
    assign done = (count == '0);
endmodule : psc_timer
